//--- shared/hpp_cfg.svh
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH

`define HPP_A_CFG 3'h0
`define HPP_A_DMAC0 3'h1
`define HPP_A_DMAC1 3'h2
`define HPP_A_EPB0 3'h3
`define HPP_A_EPB1 3'h4
`define HPP_A_STAT 3'h5

`define HPP_CFG_RESET 32'h00000020
`define HPP_HW_LO 4
`define HPP_HW_HI 5
`define HPP_ORDER_BIT 6
`define HPP_FLUSH_BIT 7
`define HPP_BLK0_BIT 8
`define HPP_BLK1_BIT 9
`define HPP_OD_BIT 16

`define HPP_DEN_BIT 0
`define HPP_TRAN_BIT 2
`define HPP_PM_LO 6
`define HPP_PM_HI 7
`define HPP_INIT_BIT 10
`define HPP_HSK_BIT 11
`define HPP_EXT_BIT 12
`define HPP_DMAC_RESET 32'h00000000

`define HPP_CHAN_BASE 8
`define HPP_FLUSH_LAT 2
`define HPP_SETW_WAIT 4

`endif

//--- shared/hpp_pkg.sv
package hpp_pkg;

    typedef enum logic [1:0] {
        HPP_HW32 = 2'b00,
        HPP_HW16 = 2'b01,
        HPP_HW8 = 2'b10,
        HPP_HWRSV = 2'b11
    } hpp_width_t;

    typedef enum logic [1:0] {
        HPP_PM_INVALID = 2'b00,
        HPP_PM_32 = 2'b01,
        HPP_PM_48 = 2'b10,
        HPP_PM_48B = 2'b11
    } hpp_packing_mode_field_t;

    typedef enum logic [1:0] {
        HPP_D_IDLE = 2'b00,
        HPP_D_WORK = 2'b01,
        HPP_D_DONE = 2'b10
    } hpp_dstate_t;

    typedef enum logic [2:0] {
        HPP_H_IDLE = 3'b000,
        HPP_H_DMAREQ = 3'b001,
        HPP_H_STROBE = 3'b010,
        HPP_H_RELEASE = 3'b011,
        HPP_H_WAIT = 3'b100
    } hpp_hstate_t;

    typedef enum logic [1:0] {
        HPP_C_READ = 2'b00,
        HPP_C_WRITE = 2'b01,
        HPP_C_SETW = 2'b10,
        HPP_C_DMAWR = 2'b11
    } hpp_cmd_t;

endpackage

//--- shared/hpp_if.sv
`timescale 1ns/1ns
interface hpp_if;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] addr;
    logic [31:0] host_data_o;
    logic host_data_oe;
    logic [31:0] dev_data_o;
    logic dev_data_oe;
    logic dev_ready_o;
    logic dev_ready_oe;
    logic [1:0] dma_request_line_n;
    logic [1:0] dma_grant_line_n;
    logic host_bus_request_n;
    logic [31:0] data;
    logic access_ready;

    // The ready line has a pull-up; with open-drain select only the low level is driven.
    assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 32'h00000000);
    assign access_ready = dev_ready_oe ? dev_ready_o : 1'b1;

    modport host (
        output cs_n, rd_n, wr_n, addr, host_data_o, host_data_oe,
        output dma_request_line_n, host_bus_request_n,
        input data, access_ready, dma_grant_line_n
    );
    modport dev (
        input cs_n, rd_n, wr_n, addr, data, dma_request_line_n, host_bus_request_n,
        output dev_data_o, dev_data_oe, dev_ready_o, dev_ready_oe, dma_grant_line_n
    );
endinterface

//--- logic/hpp_device.sv
`timescale 1ns/1ns
`include "hpp_cfg.svh"

module hpp_fifo #(
    parameter int W = 48,
    parameter int D = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    assign out_valid = wr_ptr != rd_ptr;
    assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module hpp_device #(
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    hpp_if.dev bus,
    input wire logic core_cfg_wr,
    input wire logic [31:0] core_cfg_data,
    output logic [1:0] core_rx_valid,
    input wire logic [1:0] core_rx_ready,
    output logic [1:0][47:0] core_rx_data,
    input wire logic [1:0] core_tx_valid,
    output logic [1:0] core_tx_ready,
    input wire logic [1:0][47:0] core_tx_data,
    output logic block0_width_select,
    output logic block1_width_select,
    output logic [2:0] packing_pending_status
);
    import hpp_pkg::*;

    function automatic logic [5:0] part_bits(hpp_width_t hw);
        // A reserved code is not supported; it is handled like the widest bus.
        unique case (hw)
            HPP_HW16: part_bits = 6'd16;
            HPP_HW8: part_bits = 6'd8;
            HPP_HW32, HPP_HWRSV: part_bits = 6'd32;
        endcase
    endfunction

    function automatic logic [2:0] parts_of(hpp_width_t hw, logic wide);
        logic [5:0] b;
        b = part_bits(hw);
        if (wide) begin
            parts_of = (b == 6'd32) ? 3'd2 : ((b == 6'd16) ? 3'd3 : 3'd6);
        end else begin
            parts_of = (b == 6'd32) ? 3'd1 : ((b == 6'd16) ? 3'd2 : 3'd4);
        end
    endfunction

    function automatic logic [31:0] lane_mask(hpp_width_t hw);
        lane_mask = 32'hFFFFFFFF >> (6'd32 - part_bits(hw));
    endfunction

    function automatic logic [5:0] part_shift(hpp_width_t hw, logic msw, logic wide,
                                              logic [2:0] idx);
        logic [2:0] pos;
        pos = msw ? 3'(parts_of(hw, wide) - 3'd1 - idx) : idx;
        part_shift = 6'(pos * part_bits(hw));
    endfunction

    function automatic logic [47:0] place(logic [47:0] buf_in, logic [31:0] part,
                                          hpp_width_t hw, logic msw, logic wide,
                                          logic [2:0] idx);
        logic [47:0] m;
        logic [5:0] sh;
        m = {16'h0000, lane_mask(hw)};
        sh = part_shift(hw, msw, wide, idx);
        // Order is ignored for 32-to-48 packing: upper 16 bits always come first.
        if (wide && part_bits(hw) == 6'd32) begin
            place = (idx == 3'd0) ? {part[15:0], buf_in[31:0]} : {buf_in[47:32], part};
        end else begin
            place = (buf_in & ~(m << sh)) | (({16'h0000, part} & m) << sh);
        end
    endfunction

    function automatic logic [31:0] extract(logic [47:0] word, hpp_width_t hw, logic msw,
                                            logic wide, logic [2:0] idx);
        if (wide && part_bits(hw) == 6'd32) begin
            extract = (idx == 3'd0) ? {16'h0000, word[47:32]} : word[31:0];
        end else begin
            extract = 32'(word >> part_shift(hw, msw, wide, idx));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    logic [39:0] pin_s1;
    logic [39:0] pin_s2;
    logic s_cs_n;
    logic s_rd_n;
    logic s_wr_n;
    logic [2:0] s_addr;
    logic [31:0] s_data;
    logic [1:0] s_req_n;
    hpp_dstate_t state;
    logic [31:0] cfg;
    logic [1:0][31:0] dmac;
    logic [1:0] flush_pipe;
    logic op_wr;
    logic [2:0] op_addr;
    logic [31:0] op_part;
    logic [47:0] pack_buf;
    logic [47:0] rd_word;
    logic [2:0] pack_cnt;
    logic [31:0] dout;
    logic [1:0] grant_n;
    logic [1:0] rx_in_ready;
    logic [1:0] tx_out_valid;
    logic [1:0][47:0] tx_out_data;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1 <= 40'hFFFFFFFFFF;
            pin_s2 <= 40'hFFFFFFFFFF;
        end else begin
            pin_s1 <= {bus.cs_n, bus.rd_n, bus.wr_n, bus.addr, bus.data, bus.dma_request_line_n};
            pin_s2 <= pin_s1;
        end
    end
    assign {s_cs_n, s_rd_n, s_wr_n, s_addr, s_data, s_req_n} = pin_s2;

    hpp_width_t hw;
    logic msw;
    logic is_epb;
    logic ch;
    logic ext;
    logic wide;
    logic epb_ok;
    logic last;
    logic [2:0] nparts;
    logic [47:0] asm_word;
    logic [47:0] src_word;
    logic stall;
    logic commit;
    logic pop;

    always_comb begin
        hw = hpp_width_t'(cfg[`HPP_HW_HI:`HPP_HW_LO]);
        msw = cfg[`HPP_ORDER_BIT];
        is_epb = (op_addr == `HPP_A_EPB0) || (op_addr == `HPP_A_EPB1);
        ch = op_addr == `HPP_A_EPB1;
        ext = dmac[ch][`HPP_HSK_BIT] && dmac[ch][`HPP_EXT_BIT] && !dmac[ch][`HPP_INIT_BIT];
        wide = is_epb && dmac[ch][`HPP_PM_HI] && !ext;
        epb_ok = (ext || dmac[ch][`HPP_PM_HI:`HPP_PM_LO] != HPP_PM_INVALID)
            && (dmac[ch][`HPP_DEN_BIT] ? (dmac[ch][`HPP_TRAN_BIT] == op_wr)
                : (dmac[ch][`HPP_TRAN_BIT] != op_wr));
        nparts = (is_epb && ext) ? 3'd1 : parts_of(hw, wide);
        last = pack_cnt == 3'(nparts - 3'd1);
        asm_word = (is_epb && ext) ? {16'h0000, op_part} : place(pack_buf, op_part, hw, msw, wide,
            pack_cnt);
        unique case (op_addr)
            `HPP_A_CFG: src_word = {16'h0000, cfg};
            `HPP_A_DMAC0: src_word = {16'h0000, dmac[0]};
            `HPP_A_DMAC1: src_word = {16'h0000, dmac[1]};
            `HPP_A_STAT: src_word = {45'h0, pack_cnt};
            default: src_word = (is_epb && epb_ok) ? tx_out_data[ch] : 48'h000000000000;
        endcase
        // Buffer accesses with a valid packing mode and matching direction wait for room or data instead of failing.
        stall = is_epb && epb_ok && (op_wr ? (last && !rx_in_ready[ch])
            : (pack_cnt == 3'd0 && !tx_out_valid[ch]));
        commit = (state == HPP_D_WORK) && !stall && op_wr && last;
        pop = (state == HPP_D_WORK) && !stall && !op_wr && pack_cnt == 3'd0 && is_epb && epb_ok;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= HPP_D_IDLE;
            op_wr <= 1'b0;
            op_addr <= 3'h0;
            op_part <= 32'h00000000;
        end else begin
            unique case (state)
                HPP_D_IDLE: begin
                    // Chip select with exactly one of the read and write strobes low qualifies an access, so broadcast writes are taken.
                    if (!s_cs_n && (s_rd_n != s_wr_n)) begin
                        state <= HPP_D_WORK;
                        op_wr <= !s_wr_n;
                        op_addr <= s_addr;
                        op_part <= s_data & lane_mask(hw);
                    end
                end
                HPP_D_WORK: begin
                    if (!stall) begin
                        state <= HPP_D_DONE;
                    end
                end
                HPP_D_DONE: begin
                    if (s_cs_n || (s_rd_n && s_wr_n)) begin
                        state <= HPP_D_IDLE;
                    end
                end
                default: state <= HPP_D_IDLE;
            endcase
        end
    end

    // Partial words survive between accesses; only a flush or completion clears them.
    always_ff @(posedge clk) begin
        if (rst) begin
            pack_cnt <= 3'd0;
            pack_buf <= 48'h000000000000;
            rd_word <= 48'h000000000000;
            dout <= 32'h00000000;
        end else if (flush_pipe[1]) begin
            pack_cnt <= 3'd0;
        end else if (state == HPP_D_WORK && !stall) begin
            pack_cnt <= last ? 3'd0 : 3'(pack_cnt + 3'd1);
            if (op_wr) begin
                pack_buf <= last ? 48'h000000000000 : asm_word;
            end else if (pack_cnt == 3'd0) begin
                rd_word <= src_word;
                dout <= extract(src_word, hw, msw, wide, 3'd0) & lane_mask(hw);
            end else begin
                dout <= extract(rd_word, hw, msw, wide, pack_cnt) & lane_mask(hw);
            end
        end
    end
    assign packing_pending_status = pack_cnt;

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg <= `HPP_CFG_RESET;
            dmac <= {`HPP_DMAC_RESET, `HPP_DMAC_RESET};
            flush_pipe <= 2'b00;
        end else begin
            flush_pipe <= {flush_pipe[0], 1'b0};
            if (core_cfg_wr) begin
                cfg <= core_cfg_data & ~(32'h1 << `HPP_FLUSH_BIT);
                flush_pipe[0] <= core_cfg_data[`HPP_FLUSH_BIT];
            end else if (commit && op_addr == `HPP_A_CFG) begin
                cfg <= asm_word[31:0] & ~(32'h1 << `HPP_FLUSH_BIT);
                flush_pipe[0] <= asm_word[`HPP_FLUSH_BIT];
            end
            if (commit && op_addr == `HPP_A_DMAC0) begin
                dmac[0] <= asm_word[31:0];
            end
            if (commit && op_addr == `HPP_A_DMAC1) begin
                dmac[1] <= asm_word[31:0];
            end
        end
    end
    assign block0_width_select = cfg[`HPP_BLK0_BIT];
    assign block1_width_select = cfg[`HPP_BLK1_BIT];

    // Grants follow the request lines in handshake mode with room or data; the host bus request is not looked at.
    always_ff @(posedge clk) begin
        if (rst) begin
            grant_n <= 2'b11;
        end else begin
            for (int c = 0; c < 2; c++) begin
                grant_n[c] <= !(dmac[c][`HPP_HSK_BIT] && !dmac[c][`HPP_INIT_BIT]
                    && !s_req_n[c] && (dmac[c][`HPP_TRAN_BIT] ? rx_in_ready[c]
                    : tx_out_valid[c]));
            end
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_chan
        hpp_fifo #(.W(48), .D(DEPTH)) u_rx (
            .clk(clk),
            .rst(rst),
            .in_valid(commit && is_epb && epb_ok && ch == 1'(c)),
            .in_ready(rx_in_ready[c]),
            .in_data(asm_word),
            .out_valid(core_rx_valid[c]),
            .out_ready(core_rx_ready[c]),
            .out_data(core_rx_data[c])
        );
        hpp_fifo #(.W(48), .D(DEPTH)) u_tx (
            .clk(clk),
            .rst(rst),
            .in_valid(core_tx_valid[c]),
            .in_ready(core_tx_ready[c]),
            .in_data(core_tx_data[c]),
            .out_valid(tx_out_valid[c]),
            .out_ready(pop && ch == 1'(c)),
            .out_data(tx_out_data[c])
        );
    end

    assign bus.dma_grant_line_n = grant_n;
    assign bus.dev_data_o = dout;
    assign bus.dev_data_oe = (state == HPP_D_DONE) && !op_wr && !s_cs_n;
    // In open-drain mode the high level is left to the wired pull-up of all devices.
    assign bus.dev_ready_o = cfg[`HPP_OD_BIT] ? 1'b0 : (state == HPP_D_DONE);
    assign bus.dev_ready_oe = cfg[`HPP_OD_BIT] ? (state != HPP_D_DONE) : 1'b1;
endmodule

//--- logic/hpp_host.sv
`timescale 1ns/1ns
`include "hpp_cfg.svh"

module hpp_host (
    input wire logic clk,
    input wire logic rst,
    hpp_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire hpp_pkg::hpp_cmd_t cmd_kind,
    input wire logic [2:0] cmd_addr,
    input wire logic [31:0] cmd_data,
    input wire logic cmd_chan,
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    output hpp_pkg::hpp_width_t cur_width
);
    import hpp_pkg::*;

    logic [34:0] pin_s1;
    logic [34:0] pin_s2;
    logic s_ready;
    logic [31:0] s_data;
    logic [1:0] s_grant_n;
    hpp_hstate_t state;
    hpp_cmd_t kind;
    logic [2:0] addr;
    logic [31:0] word;
    logic chan;
    logic [1:0] phase;
    logic [2:0] part;
    logic [2:0] wait_cnt;
    logic cur_msw;
    logic [2:0] nparts;
    logic [5:0] bits;
    logic [5:0] sh;
    logic [31:0] lane;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1 <= {1'b0, 32'h00000000, 2'b11};
            pin_s2 <= {1'b0, 32'h00000000, 2'b11};
        end else begin
            pin_s1 <= {bus.access_ready, bus.data, bus.dma_grant_line_n};
            pin_s2 <= pin_s1;
        end
    end
    assign {s_ready, s_data, s_grant_n} = pin_s2;

    // Every word goes out in parts of the width in force; buffers must hold 32-bit words.
    always_comb begin
        bits = (cur_width == HPP_HW16) ? 6'd16 : ((cur_width == HPP_HW8) ? 6'd8 : 6'd32);
        nparts = (bits == 6'd8) ? 3'd4 : ((bits == 6'd16) ? 3'd2 : 3'd1);
        lane = 32'hFFFFFFFF >> (6'd32 - bits);
        sh = 6'((cur_msw ? 3'(nparts - 3'd1 - part) : part) * bits);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= HPP_H_IDLE;
            kind <= HPP_C_READ;
            addr <= 3'h0;
            word <= 32'h00000000;
            chan <= 1'b0;
            phase <= 2'd0;
            part <= 3'd0;
            wait_cnt <= 3'd0;
            cur_width <= HPP_HW8;
            cur_msw <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 32'h00000000;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state)
                HPP_H_IDLE: begin
                    if (cmd_valid) begin
                        kind <= cmd_kind;
                        addr <= (cmd_kind == HPP_C_SETW) ? `HPP_A_CFG : cmd_addr;
                        word <= cmd_data;
                        chan <= cmd_chan;
                        phase <= 2'd0;
                        part <= 3'd0;
                        state <= (cmd_kind == HPP_C_DMAWR) ? HPP_H_DMAREQ : HPP_H_STROBE;
                    end
                end
                HPP_H_DMAREQ: begin
                    if (!s_grant_n[chan]) begin
                        state <= HPP_H_STROBE;
                    end
                end
                HPP_H_STROBE: begin
                    if (s_ready) begin
                        rsp_data <= (rsp_data & ~(lane << sh)) | ((s_data & lane) << sh);
                        state <= HPP_H_RELEASE;
                    end
                end
                HPP_H_RELEASE: begin
                    if (!s_ready) begin
                        if (part != 3'(nparts - 3'd1)) begin
                            part <= part + 3'd1;
                            state <= HPP_H_STROBE;
                        end else if (kind == HPP_C_SETW && phase != 2'd2) begin
                            // Width changes once the first full write lands.
                            if (phase == 2'd0) begin
                                cur_width <= hpp_width_t'(word[`HPP_HW_HI:`HPP_HW_LO]);
                                cur_msw <= word[`HPP_ORDER_BIT];
                            end
                            phase <= phase + 2'd1;
                            part <= 3'd0;
                            state <= HPP_H_STROBE;
                        end else if (kind == HPP_C_SETW) begin
                            wait_cnt <= 3'd0;
                            state <= HPP_H_WAIT;
                        end else begin
                            rsp_valid <= kind == HPP_C_READ;
                            state <= HPP_H_IDLE;
                        end
                    end
                end
                HPP_H_WAIT: begin
                    if (wait_cnt == 3'(`HPP_SETW_WAIT - 1)) begin
                        state <= HPP_H_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt + 3'd1;
                    end
                end
                default: state <= HPP_H_IDLE;
            endcase
        end
    end

    logic rd_phase;
    assign rd_phase = (kind == HPP_C_READ) || (kind == HPP_C_SETW && phase == 2'd1);
    assign cmd_ready = state == HPP_H_IDLE;
    assign bus.cs_n = state != HPP_H_STROBE;
    assign bus.rd_n = !(state == HPP_H_STROBE && rd_phase);
    assign bus.wr_n = !(state == HPP_H_STROBE && !rd_phase);
    assign bus.addr = addr;
    assign bus.host_data_o = word >> sh;
    assign bus.host_data_oe = state == HPP_H_STROBE && !rd_phase;
    // Handshake DMA goes through the request lines, never with the bus held.
    assign bus.dma_request_line_n = (kind == HPP_C_DMAWR && state != HPP_H_IDLE)
        ? ~(2'b01 << chan) : 2'b11;
    assign bus.host_bus_request_n = !(state != HPP_H_IDLE && kind != HPP_C_DMAWR);
endmodule

//--- sim/hpp_port_chk.sv
`timescale 1ns/1ns
module hpp_port_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [2:0] addr,
    input wire logic dev_data_oe,
    input wire logic access_ready,
    input wire logic [1:0] dma_request_line_n,
    input wire logic [1:0] dma_grant_line_n,
    input wire logic host_bus_request_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_held;
        (!cs_n && $stable(addr)) [*2];
    endsequence
    property p_hold;
        !cs_n && !access_ready |=> s_held;
    endproperty
    property p_rdy_cause;
        $rose(access_ready) |-> $past(!cs_n) && $past(!cs_n, 2);
    endproperty
    property p_rdy_stand;
        access_ready && !cs_n |=> access_ready;
    endproperty
    property p_rdy_idle;
        cs_n [*4] |-> !access_ready;
    endproperty
    property p_oe_read;
        dev_data_oe |-> $past(!rd_n, 3);
    endproperty
    property p_oe_rdy;
        dev_data_oe |-> access_ready && wr_n;
    endproperty
    // The grant path is two sync stages plus a register, so it trails the request.
    property p_grant;
        !dma_grant_line_n[0] |-> $past(!dma_request_line_n[0], 3)
            || $past(!dma_request_line_n[0], 2);
    endproperty
    property p_no_both;
        !host_bus_request_n |-> dma_request_line_n == 2'h3;
    endproperty
    a_hold: assert property (p_hold) else $error("access dropped early");
    a_rdy_cause: assert property (p_rdy_cause) else $error("ready without select");
    a_rdy_stand: assert property (p_rdy_stand) else $error("ready fell early");
    a_rdy_idle: assert property (p_rdy_idle) else $error("ready while idle");
    a_oe_read: assert property (p_oe_read) else $error("drive without read");
    a_oe_rdy: assert property (p_oe_rdy) else $error("drive without ready");
    a_grant: assert property (p_grant) else $error("grant without request");
    a_no_both: assert property (p_no_both) else $error("request during bus hold");
endmodule

//--- sim/host_port_packing_dma_modes_test.sv
`timescale 1ns/1ns
module host_port_packing_dma_modes_test;
    import hpp_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic cmd_valid = 0;
    hpp_cmd_t cmd_kind = HPP_C_READ;
    logic [2:0] cmd_addr = 0;
    logic [31:0] cmd_data = 0;
    logic [1:0] rx_rdy = 2'h2;
    logic [1:0] tx_val = 0;
    logic [1:0][47:0] tx_dat = '0;
    logic cmd_ready, rsp_valid, b0, b1;
    logic [31:0] rsp_data, rd, v;
    hpp_width_t cur_width;
    logic [1:0] rx_val, tx_rdy;
    logic [1:0][47:0] rx_dat;
    logic [2:0] pend;
    logic [31:0] exp_q[$];
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    hpp_if bus();
    hpp_host u_hpp_host (.clk(clk), .rst(rst), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_chan(1'b0), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cur_width(cur_width));
    hpp_device #(.DEPTH(4)) u_hpp_device (.clk(clk), .rst(rst), .bus(bus), .core_cfg_wr(1'b0),
        .core_cfg_data(32'h0), .core_rx_valid(rx_val), .core_rx_ready(rx_rdy),
        .core_rx_data(rx_dat), .core_tx_valid(tx_val), .core_tx_ready(tx_rdy),
        .core_tx_data(tx_dat), .block0_width_select(b0), .block1_width_select(b1),
        .packing_pending_status(pend));
    hpp_port_chk u_hpp_port_chk (.clk(clk), .rst(rst), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
        .wr_n(bus.wr_n), .addr(bus.addr), .dev_data_oe(bus.dev_data_oe),
        .access_ready(bus.access_ready), .dma_request_line_n(bus.dma_request_line_n),
        .dma_grant_line_n(bus.dma_grant_line_n), .host_bus_request_n(bus.host_bus_request_n));
    initial begin
        forever #50 clk = ~clk;
    end
    task chk(input string n, input logic [47:0] s, input logic [47:0] e);
        check_count++;
        if (s !== e) begin
            $display("unexpected %s exp %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task cmd(input hpp_cmd_t k, input logic [2:0] a, input logic [31:0] d);
        @(negedge clk);
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_kind = k;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1;
        @(negedge clk);
        cmd_valid = 0;
        for (int i = 0; i < 900 && cmd_ready !== 1'b1; i++) begin
            @(negedge clk);
            if (rsp_valid === 1'b1) rd = rsp_data;
        end
        if (cmd_ready !== 1'b1) num_errors++;
    endtask
    // Upper lanes are checked on the wire, since the host model would hide them.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up;
        end
        if (bus.dev_data_oe === 1'b1 && cur_width !== HPP_HW32)
            chk("hi", bus.data & (cur_width === HPP_HW8 ? 32'hFFFFFF00 : 32'hFFFF0000), 0);
        if (rx_val[0] === 1'b1 && rx_rdy[0] === 1'b1)
            chk("rx", rx_dat[0][31:0], exp_q.size() ? exp_q.pop_front() : 'x);
    end
    initial begin
        void'($urandom(32'hEEF8));
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 0;
        cmd(HPP_C_READ, `HPP_A_CFG, 0);
        chk("cfg", rd, `HPP_CFG_RESET);
        v = 32'h100A0 | ($urandom & 32'h300);
        cmd(HPP_C_WRITE, `HPP_A_CFG, v);
        cmd(HPP_C_READ, `HPP_A_CFG, 0);
        chk("cfg", rd, v & ~32'h80);
        chk("blk", {b1, b0}, v[9:8]);
        v = (v & ~32'hB0) | 32'h10;
        cmd(HPP_C_SETW, `HPP_A_CFG, v);
        chk("width", cur_width, HPP_HW16);
        cmd(HPP_C_READ, `HPP_A_CFG, 0);
        chk("cfg16", rd, v);
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'h1CC5;
            cmd(HPP_C_WRITE, 3'(1 + i % 2), v);
            cmd(HPP_C_READ, 3'(1 + i % 2), 0);
            chk("ctl", rd, v);
        end
        cmd(HPP_C_WRITE, 3'h7, $urandom);
        cmd(HPP_C_READ, 3'h7, 0);
        chk("unmapped", rd, 0);
        cmd(HPP_C_WRITE, `HPP_A_DMAC0, 32'h4);
        cmd(HPP_C_READ, `HPP_A_EPB0, 0);
        chk("pm00", rd, 0);
        cmd(HPP_C_WRITE, `HPP_A_DMAC0, 32'h40);
        for (int i = 0; i < 5; i++) begin
            v = $urandom;
            exp_q.push_back(v);
            if (i < 4) cmd(HPP_C_WRITE, `HPP_A_EPB0, v);
        end
        fork
            cmd(HPP_C_WRITE, `HPP_A_EPB0, v);
        join_none
        repeat (200) @(posedge clk);
        chk("wstall", cmd_ready, 0);
        chk("pend1", pend, 1);
        @(negedge clk);
        rx_rdy = 2'h3;
        wait fork;
        cmd(HPP_C_WRITE, `HPP_A_DMAC1, 32'h44);
        v = $urandom;
        fork
            cmd(HPP_C_READ, `HPP_A_EPB1, 0);
        join_none
        repeat (100) @(posedge clk);
        chk("rstall", cmd_ready, 0);
        @(negedge clk);
        tx_dat[1] = {16'h0, v};
        tx_val = 2'h2;
        @(posedge clk);
        while (tx_rdy[1] !== 1'b1) @(posedge clk);
        @(negedge clk);
        tx_val = 0;
        wait fork;
        chk("rd", rd, v);
        cmd(HPP_C_READ, `HPP_A_STAT, 0);
        chk("pend", rd, 0);
        cmd(HPP_C_WRITE, `HPP_A_DMAC0, 32'h845);
        v = $urandom;
        exp_q.push_back(v);
        cmd(HPP_C_DMAWR, `HPP_A_EPB0, v);
        repeat (20) @(posedge clk);
        chk("left", exp_q.size(), 0);
        wrap_up;
    end
endmodule
